// ==== shared/fim_consts.svh ====
`ifndef FIM_CONSTS_SVH
`define FIM_CONSTS_SVH
// register byte offsets; index = offset / 4
`define FIM_OFF_CTRL   8'h00
`define FIM_OFF_GROUP  8'h04
`define FIM_OFF_REACT  8'h08
`define FIM_OFF_TOL    8'h0C
`define FIM_OFF_ASSOC0 8'h10
`define FIM_OFF_ASSOC1 8'h14
`define FIM_OFF_DOUT   8'h18
`define FIM_OFF_STAT   8'h1C
`define FIM_OFF_VALUE  8'h20
// writable bits of each stored register
`define FIM_WM_CTRL    32'hFFFF_F000
`define FIM_WM_GROUP   32'h0FFF_FFFF
`define FIM_WM_REACT   32'h0000_0077
`define FIM_WM_TOL     32'hFFFF_FF03
`define FIM_WM_ASSOC0  32'hFFFF_FFFF
`define FIM_WM_ASSOC1  32'h0000_0FFF
`define FIM_WM_DOUT    32'h0000_00FF
// reset values: both groups halt, short tolerance, n = 1, task interval 1 ms
`define FIM_RST_REACT  32'h0000_0000
`define FIM_RST_TOL    32'h0001_0100
// field positions
`define FIM_MON_LSB    12
`define FIM_OGRP_LSB   20
`define FIM_TOLN_LSB   8
`define FIM_IVAL_LSB   16
`define FIM_PAIR_LSB   8
`define FIM_ST_OFF_LSB 20
`define FIM_ST_HALT    24
`define FIM_ST_BUSY    25
// sizes
`define FIM_NIN        20
`define FIM_NOB        16
`define FIM_NOUT       8
`define FIM_NCHK       4
`define FIM_NGRP       2
// timing
`define FIM_CLK_NS     5
`define FIM_MS_NS      1000000
`define FIM_SHORT_MS   1
`define FIM_AVG_MS     5
`define FIM_SETTLE_NS  20000
`endif

// ==== shared/fim_pkg.sv ====
package fim_pkg;
  typedef enum logic [2:0] {
    FIM_HALT = 3'h0, FIM_PASSIVE = 3'h1, FIM_SUB_ZERO = 3'h2,
    FIM_SUB_ONE = 3'h3, FIM_SUB_OLD = 3'h4
  } fim_react_t;
  typedef enum logic [1:0] {
    FIM_TOL_SHORT = 2'h0, FIM_TOL_MAIN = 2'h1, FIM_TOL_TASK = 2'h2, FIM_TOL_AVG = 2'h3
  } fim_tol_t;
  typedef enum logic [1:0] {
    FIM_LT_IDLE = 2'h0, FIM_LT_DRIVE = 2'h1, FIM_LT_NEXT = 2'h2
  } fim_lt_t;
endpackage

// ==== hdl/fim_monitor.sv ====
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "fim_consts.svh"
module fim_monitor
  import fim_pkg::*;
#(
  parameter int MS_CYC = `FIM_MS_NS / `FIM_CLK_NS
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [19:0] din_pin,
  input  wire logic [19:0] twin_din,
  input  wire logic [3:0]  chk_short,
  input  wire logic [1:0]  ext_fault,
  input  wire logic        main_cycle_pulse,
  output logic [3:0]       check_q,
  output logic [7:0]       dout,
  output logic [19:0]      din_value,
  output logic             halted
);
  localparam int NI = `FIM_NIN;
  localparam int NB = `FIM_NOB;
  localparam int NC = `FIM_NCHK;
  localparam int SW = 2 * NI + NC + `FIM_NGRP;
  localparam logic [12:0] SET_CYC = 13'(`FIM_SETTLE_NS / `FIM_CLK_NS);

  logic [SW-1:0] s1, s2, s3, sv, next_sv;
  logic [NI-1:0] own, twin;
  logic [NC-1:0] shrt;
  logic [1:0]    xflt;
  logic [31:0]   cfg [0:6];
  logic [31:0]   next_cfg [0:6];
  logic          next_awready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]    next_bresp, next_rresp;
  logic [31:0]   next_rdata, stat, clr_w;
  logic          wr, rd, go;
  logic [NI-1:0] clr_f, fault, next_fault, set_f, last, next_last, eff;
  logic [NI-1:0] pas_in, or_in, mon;
  logic [7:0]    tcnt [0:NI-1];
  logic [7:0]    next_tcnt [0:NI-1];
  logic [7:0]    lim_v [0:NI-1];
  logic [1:0]    md;
  logic [39:0]   asg;
  logic [31:0]   ms_cnt, next_ms_cnt;
  logic [15:0]   per_cnt, next_per_cnt;
  logic          ms_tick, per_tick;
  fim_react_t    rg [0:1];
  logic [1:0]    gfault;
  logic [7:0]    next_dout, pas_out;
  logic          next_halted;
  fim_lt_t       st, next_st;
  logic [1:0]    lt_k, next_k;
  logic [12:0]   lt_cnt, next_lc;
  logic [NC-1:0] chk_off, next_off, used, next_check_q;
  logic          lt_samp;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  function automatic logic fim_okay(logic [7:0] a);
    return a[1:0] == 2'h0 && a <= `FIM_OFF_VALUE;
  endfunction

  function automatic logic [31:0] fim_merge(logic [31:0] o, logic [31:0] d, logic [3:0] s);
    for (int b = 0; b < 4; b++) o[8*b+:8] = s[b] ? d[8*b+:8] : o[8*b+:8];
    return o;
  endfunction

  function automatic logic [31:0] fim_wmask(logic [2:0] ix);
    case (ix)
      3'h0:    return `FIM_WM_CTRL;
      3'h1:    return `FIM_WM_GROUP;
      3'h2:    return `FIM_WM_REACT;
      3'h3:    return `FIM_WM_TOL;
      3'h4:    return `FIM_WM_ASSOC0;
      3'h5:    return `FIM_WM_ASSOC1;
      3'h6:    return `FIM_WM_DOUT;
      default: return 32'h0000_0000;
    endcase
  endfunction

  // tick that advances a tolerance counter for a mode
  function automatic logic fim_tick(logic [1:0] m, logic msk, logic cyc, logic tsk);
    case (m)
      FIM_TOL_MAIN: return cyc;
      FIM_TOL_TASK: return tsk;
      default:      return msk;
    endcase
  endfunction

  // tolerance limit in ticks for a mode
  function automatic logic [7:0] fim_lim(logic [1:0] m, logic [7:0] n);
    case (m)
      FIM_TOL_SHORT: return 8'(`FIM_SHORT_MS);
      FIM_TOL_AVG:   return 8'(`FIM_AVG_MS);
      default:       return n;
    endcase
  endfunction

  // pins: three stages, a change counts once stages two and three agree
  always_comb begin
    next_sv = (s2 & s3) | (sv & (s2 | s3));
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      sv <= '0;
    end else begin
      s1 <= {ext_fault, chk_short, twin_din, din_pin};
      s2 <= s1;
      s3 <= s2;
      sv <= next_sv;
    end
  end
  assign {xflt, shrt, twin, own} = sv;

  // register bus: write and read handshakes, config storage
  assign wr = awvalid && awready && wvalid && wready;
  assign rd = arvalid && arready;
  assign go = wr && fim_okay(awaddr) && awaddr == `FIM_OFF_CTRL && wstrb[0] && wdata[0];
  // write-one-to-clear mask for the fault flags, per byte lane
  assign clr_w = fim_merge(32'h0, wdata, wstrb);
  assign clr_f = (wr && fim_okay(awaddr) && awaddr == `FIM_OFF_STAT) ? clr_w[NI-1:0] : '0;
  assign stat = {6'h0, st != FIM_LT_IDLE, halted, chk_off, fault};
  always_comb begin
    next_cfg = cfg;
    next_awready = awvalid && wvalid && !awready && !bvalid;
    next_bvalid = bvalid && !bready;
    next_bresp = bresp;
    next_arready = arvalid && !arready && !rvalid;
    next_rvalid = rvalid && !rready;
    next_rresp = rresp;
    next_rdata = rdata;
    if (wr) begin
      next_bvalid = 1'b1;
      next_bresp = fim_okay(awaddr) ? 2'h0 : 2'h2;
      if (fim_okay(awaddr) && awaddr < `FIM_OFF_STAT) begin
        next_cfg[awaddr[4:2]] = fim_merge(cfg[awaddr[4:2]], wdata, wstrb)
                                & fim_wmask(awaddr[4:2]);
      end
    end
    if (rd) begin
      next_rvalid = 1'b1;
      next_rresp = fim_okay(araddr) ? 2'h0 : 2'h2;
      if (!fim_okay(araddr)) next_rdata = 32'h0;
      else if (araddr == `FIM_OFF_STAT) next_rdata = stat;
      else if (araddr == `FIM_OFF_VALUE) next_rdata = {12'h0, din_value};
      else next_rdata = cfg[araddr[4:2]];
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= 2'h0;
      rdata <= 32'h0;
      for (int j = 0; j < 7; j++) cfg[j] <= 32'h0;
      cfg[2] <= `FIM_RST_REACT;
      cfg[3] <= `FIM_RST_TOL;
    end else begin
      awready <= next_awready;
      wready <= next_awready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      cfg <= next_cfg;
    end
  end

  // discrepancy analysis, fault flags and group reactions
  assign mon = cfg[0][`FIM_MON_LSB+:NI];
  assign asg = {cfg[5][7:0], cfg[4]};
  assign rg[0] = fim_react_t'(cfg[2][2:0]);
  assign rg[1] = fim_react_t'(cfg[2][6:4]);
  assign ms_tick = ms_cnt == 32'(MS_CYC - 1);
  assign per_tick = ms_tick && per_cnt == cfg[3][`FIM_IVAL_LSB+:16] - 16'h1;
  always_comb begin
    next_ms_cnt = ms_tick ? 32'h0 : ms_cnt + 32'h1;
    next_per_cnt = per_cnt;
    if (per_tick) next_per_cnt = 16'h0;
    else if (ms_tick) next_per_cnt = per_cnt + 16'h1;
    md = 2'h0;
    set_f = '0;
    next_last = last;
    pas_in = '0;
    or_in = '0;
    for (int g = 0; g < 2; g++) begin
      gfault[g] = |(fault & (g[0] ? cfg[1][NI-1:0] : ~cfg[1][NI-1:0])) | xflt[g];
    end
    for (int i = 0; i < NI; i++) begin
      next_tcnt[i] = tcnt[i];
      md = (i >= NB) ? FIM_TOL_SHORT : cfg[3][1:0];
      lim_v[i] = fim_lim(md, cfg[3][`FIM_TOLN_LSB+:8]);
      if (own[i] == twin[i]) begin
        next_tcnt[i] = 8'h0;
        if (!fault[i]) next_last[i] = own[i];
      end else if (fim_tick(md, ms_tick, main_cycle_pulse, per_tick) && tcnt[i] != 8'hFF) begin
        next_tcnt[i] = tcnt[i] + 8'h1;
      end
      if (tcnt[i] > lim_v[i]) set_f[i] = 1'b1;
      if (lt_samp && mon[i]) begin
        set_f[i] = set_f[i] | ((asg[2*i+:2] == lt_k) ? own[i] : !own[i]);
      end
      pas_in[i] = gfault[cfg[1][i]] && rg[cfg[1][i]] == FIM_PASSIVE;
      or_in[i] = fault[i] && !pas_in[i] && !halted && rg[cfg[1][i]] == FIM_SUB_ONE;
      if (halted || pas_in[i]) eff[i] = 1'b0;
      else if (!fault[i]) eff[i] = own[i];
      else if (rg[cfg[1][i]] == FIM_SUB_ONE) eff[i] = 1'b1;
      else if (rg[cfg[1][i]] == FIM_SUB_OLD) eff[i] = last[i];
      else eff[i] = 1'b0;
    end
    next_fault = (fault & ~clr_f) | set_f;
    // halt is settled first, the output gating below reads it
    next_halted = halted | (gfault[0] && rg[0] == FIM_HALT) | (gfault[1] && rg[1] == FIM_HALT);
    for (int j = 0; j < 8; j++) begin
      pas_out[j] = gfault[cfg[1][`FIM_OGRP_LSB+j]] && rg[cfg[1][`FIM_OGRP_LSB+j]] == FIM_PASSIVE;
      next_dout[j] = cfg[6][j] && !next_halted && !pas_out[j];
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ms_cnt <= 32'h0;
      per_cnt <= 16'h0;
      fault <= '0;
      last <= '0;
      halted <= 1'b0;
      dout <= 8'h0;
      din_value <= '0;
      for (int i = 0; i < NI; i++) tcnt[i] <= 8'h0;
    end else begin
      ms_cnt <= next_ms_cnt;
      per_cnt <= next_per_cnt;
      fault <= next_fault;
      last <= next_last;
      halted <= next_halted;
      dout <= next_dout;
      din_value <= eff;
      tcnt <= next_tcnt;
    end
  end

  AST_HALT_ENTER: assert property ((gfault[0] && rg[0] == FIM_HALT) |=> halted)
    else $error("halt group fault did not halt");
  AST_HALT_HOLD: assert property (halted |=> halted [*3])
    else $error("halt left without reset");
  AST_PASS_IN: assert property (~|($past(pas_in) & din_value))
    else $error("passivated input not zero");
  AST_PASS_OUT: assert property (##1 ~|($past(pas_out) & dout))
    else $error("passivated output not cleared");
  AST_SUB_ONE: assert property (##1 ~|($past(or_in) & ~din_value))
    else $error("substitute one missing");
  AST_TOL: assert property ($rose(fault[3]) && !$past(lt_samp) |-> $past(tcnt[3] > lim_v[3]))
    else $error("fault before tolerance elapsed");
  AST_IRQ_SHORT: assert property (own[NB+1] != twin[NB+1] && !ms_tick |=>
    $stable(tcnt[NB+1]))
    else $error("interrupt byte tolerance not short");
  AST_RST_TOL: assert property ($past(!rst_b) |-> cfg[3][1:0] == FIM_TOL_SHORT)
    else $error("tolerance not short after reset");
  COV_HALT: cover property (!halted ##1 halted);
  COV_SUB_ONE: cover property (|or_in);

  // line test sequencer and check output control
  always_comb begin
    next_st = st;
    next_k = lt_k;
    next_lc = lt_cnt;
    lt_samp = 1'b0;
    next_off = chk_off;
    for (int c = 0; c < NC; c++) begin
      used[c] = cfg[5][`FIM_PAIR_LSB+c];
      for (int i = 0; i < NI; i++) used[c] = used[c] | (mon[i] && asg[2*i+:2] == c);
      if (check_q[c] && shrt[c]) next_off[c] = 1'b1;
    end
    case (st)
      FIM_LT_IDLE: begin
        if (go) begin
          next_st = FIM_LT_DRIVE;
          next_k = 2'h0;
          next_lc = 13'h0;
          next_off = next_off & shrt;
        end
      end
      FIM_LT_DRIVE: begin
        next_lc = lt_cnt + 13'h1;
        if (lt_cnt == SET_CYC - 13'h1) lt_samp = used[lt_k] && !chk_off[lt_k];
        if (lt_cnt == 13'(2 * SET_CYC - 1)) next_st = FIM_LT_NEXT;
      end
      FIM_LT_NEXT: begin
        next_lc = 13'h0;
        next_k = lt_k + 2'h1;
        next_st = (lt_k == 2'(NC - 1)) ? FIM_LT_IDLE : FIM_LT_DRIVE;
      end
      default: next_st = FIM_LT_IDLE;
    endcase
    for (int c = 0; c < NC; c++) begin
      next_check_q[c] = !next_off[c] && !(next_st == FIM_LT_DRIVE && next_k == c &&
                        next_lc < SET_CYC && used[c]);
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st <= FIM_LT_IDLE;
      lt_k <= 2'h0;
      lt_cnt <= 13'h0;
      chk_off <= '0;
      check_q <= 4'h0;
    end else begin
      st <= next_st;
      lt_k <= next_k;
      lt_cnt <= next_lc;
      chk_off <= next_off;
      check_q <= next_check_q;
    end
  end

  AST_ONE_LOW: assert property ($past(rst_b) |->
    $onehot0(~check_q & ~chk_off & ~$past(chk_off)))
    else $error("two check outputs low together");
  AST_IDLE_HIGH: assert property (st == FIM_LT_IDLE && $past(rst_b) |->
    check_q == ~chk_off)
    else $error("check output low outside a test");
  AST_OFF_LOW: assert property ($past(chk_off[2]) && !$past(go) |-> !check_q[2])
    else $error("disabled check output driven");
  AST_OFF_HOLD: assert property (chk_off[2] && !go |=> chk_off[2])
    else $error("check output re-enabled without test start");
  COV_TEST_END: cover property (st == FIM_LT_NEXT && lt_k == 2'h3);
  COV_SHORT: cover property ($rose(chk_off[2]));
endmodule // fim_monitor

// ==== dv/fim_field_model.sv ====
`timescale 1ns/100ps
// sensor wiring and twin subunit as seen from the monitor's pins
module fim_field_model (
  input  wire logic [3:0]  check_q,
  input  wire logic [19:0] sensor,
  input  wire logic [19:0] flip,
  input  wire logic        bridge,
  input  wire logic [3:0]  gnd_short,
  output logic [19:0]      din_pin,
  output logic [19:0]      twin_din,
  output logic [3:0]       chk_short
);
  // onboard line i is powered by check output i mod 4, four lines per output
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      din_pin[i] = sensor[i] & check_q[i % 4];
    end
    // interrupt byte lines stay off the shared check outputs
    din_pin[19:16] = sensor[19:16];
    // lines 0 and 1 touching each other
    if (bridge) begin
      din_pin[1:0] = {2{|din_pin[1:0]}};
    end
  end
  // twin reads the same lines; flip forces a discrepancy
  assign twin_din = din_pin ^ flip;
  // overcurrent sense of a check output shorted to ground
  assign chk_short = gnd_short;
endmodule // fim_field_model

// ==== dv/tb_top.sv ====
`timescale 1ns/100ps
`include "fim_consts.svh"
module tb_top;
  logic        clock, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, halted, bridge, main_cycle_pulse;
  logic [7:0]  awaddr, araddr, dout;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb, check_q, gnd, chk_short;
  logic [1:0]  bresp, rresp, resp, ext_fault;
  logic [19:0] din_pin, twin_din, din_value, sensor, flip;
  int          errors, comparisons, pcnt;
  // tolerance table: setting, input, mismatch length, fault expected
  logic [31:0] tv [9] = '{32'h0001_0100, 32'h0001_0100, 32'h0001_0301, 32'h0001_0301,
                          32'h0001_0302, 32'h0001_0302, 32'h0001_0103, 32'h0001_0103,
                          32'h0001_0301};
  int          ti [9] = '{3, 3, 3, 3, 3, 3, 3, 3, 17};
  int          td [9] = '{10, 100, 90, 400, 25, 200, 60, 300, 100};
  logic        te [9] = '{0, 1, 0, 1, 0, 1, 0, 1, 1};
  // expected values per group0 reaction 1..4
  logic [19:0] ed [4] = '{20'h8_0000, 20'hF_FFF7, 20'hF_FFFF, 20'hF_FFF7};
  logic [7:0]  eo [4] = '{8'h80, 8'hA5, 8'hA5, 8'hA5};

  fim_monitor #(.MS_CYC(20)) u_dut (
    .clock(clock), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .din_pin(din_pin), .twin_din(twin_din), .chk_short(chk_short), .ext_fault(ext_fault),
    .main_cycle_pulse(main_cycle_pulse), .check_q(check_q), .dout(dout),
    .din_value(din_value), .halted(halted));

  fim_field_model u_field (
    .check_q(check_q), .sensor(sensor), .flip(flip), .bridge(bridge), .gnd_short(gnd),
    .din_pin(din_pin), .twin_din(twin_din), .chk_short(chk_short));

  // clock and main program cycle pulse every 50 cycles
  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    pcnt <= (pcnt == 49) ? 0 : pcnt + 1;
    main_cycle_pulse <= (pcnt == 49);
  end

  task automatic stop_test;
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // write: address and data offered together, bready held high throughout
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
  endtask

  // read: only the watchdog ends a wait for the answer
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
  endtask

  // wait for the check outputs to leave a pattern
  task automatic wait_chg(input logic [3:0] old);
    int n;
    n = 0;
    while (check_q === old && n < 5000) begin
      @(posedge clock);
      n++;
    end
  endtask

  // poll the busy flag until the line test is over
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      repeat (500) @(posedge clock);
      rd(`FIM_OFF_STAT, d);
      n++;
    end while (d[`FIM_ST_BUSY] !== 1'b0 && n < 100);
    chk(d[`FIM_ST_BUSY], 1'b0);
  endtask

  // watchdog
  initial begin
    repeat (90000) @(posedge clock);
    errors++;
    stop_test();
  end

  initial begin
    clock = 0; rst_b = 0; awaddr = 0; araddr = 0; wdata = 0; wstrb = 4'hF;
    awvalid = 0; wvalid = 0; arvalid = 0; bready = 1; rready = 1;
    ext_fault = 0; sensor = 20'hF_FFF7; flip = 0; bridge = 0; gnd = 0;
    errors = 0; comparisons = 0; pcnt = 0; main_cycle_pulse = 0;
    repeat (2) @(posedge clock);
    chk(check_q, 4'h0);
    rst_b <= 1'b1;
    rd(`FIM_OFF_REACT, d);
    chk(d, 32'h0);
    rd(`FIM_OFF_TOL, d);
    chk(d, 32'h0001_0100);
    rd(8'h24, d);
    chk(resp, 2'b10);
    chk(d, 32'h0);
    wr(8'h02, 32'hFFFF_FFFF);
    chk(resp, 2'b10);
    // group 1 holds input 19 and output 7; inputs 0 to 15 follow check i mod 4
    wr(`FIM_OFF_GROUP, 32'h0808_0000);
    wr(`FIM_OFF_DOUT, 32'hA5);
    wr(`FIM_OFF_ASSOC0, 32'hE4E4_E4E4);
    wr(`FIM_OFF_ASSOC1, 32'h0);
    wr(`FIM_OFF_REACT, 32'h12);
    // discrepancy tolerance in every mode
    for (int e = 0; e < 9; e++) begin
      wr(`FIM_OFF_TOL, tv[e]);
      wr(`FIM_OFF_STAT, 32'h000F_FFFF);
      flip[ti[e]] <= 1'b1;
      repeat (td[e]) @(posedge clock);
      flip[ti[e]] <= 1'b0;
      repeat (30) @(posedge clock);
      rd(`FIM_OFF_STAT, d);
      chk(d[ti[e]], te[e]);
    end
    // clean line test: each check output low in turn, no faults
    sensor <= 20'hF_FFFF;
    wr(`FIM_OFF_STAT, 32'h000F_FFFF);
    chk(check_q, 4'hF);
    wr(`FIM_OFF_CTRL, 32'h0FFF_F001);
    for (int k = 0; k < 4; k++) begin
      wait_chg(4'hF);
      chk(check_q, 4'(~(4'h1 << k)));
      wait_chg(4'(~(4'h1 << k)));
      chk(check_q, 4'hF);
    end
    wait_idle();
    chk(d[19:0], 20'h0);
    // short to ground disables check output 2, shown in the status word but with no fault flag
    gnd <= 4'h4;
    repeat (20) @(posedge clock);
    chk(check_q, 4'hB);
    rd(`FIM_OFF_STAT, d);
    chk(d[23:0], 24'h40_0000);
    gnd <= 4'h0;
    repeat (50) @(posedge clock);
    chk(check_q, 4'hB);
    // bridged lines 0 and 1 caught by a new test, which re-enables output 2
    bridge <= 1'b1;
    wr(`FIM_OFF_CTRL, 32'h0FFF_F001);
    wait_idle();
    chk(d[23:0], 24'h00_0003);
    chk(check_q, 4'hF);
    bridge <= 1'b0;
    sensor <= 20'hF_FFF7;
    repeat (60) @(posedge clock);
    // each non-halt reaction of group 0, short tolerance so the fault lands in time
    wr(`FIM_OFF_TOL, `FIM_RST_TOL);
    for (int m = 1; m < 5; m++) begin
      wr(`FIM_OFF_REACT, 32'h10 | m);
      wr(`FIM_OFF_STAT, 32'h000F_FFFF);
      sensor[3] <= 1'b1;
      flip[3] <= 1'b1;
      repeat (100) @(posedge clock);
      chk(din_value, ed[m-1]);
      chk(dout, eo[m-1]);
      sensor[3] <= 1'b0;
      flip[3] <= 1'b0;
      repeat (60) @(posedge clock);
    end
    // external fault passivates group 1 only
    ext_fault <= 2'b10;
    repeat (20) @(posedge clock);
    chk(din_value, 20'h7_FFF7);
    chk(dout, 8'h25);
    ext_fault <= 2'b00;
    // halt reaction stops the whole system
    wr(`FIM_OFF_REACT, 32'h10);
    wr(`FIM_OFF_STAT, 32'h000F_FFFF);
    sensor[3] <= 1'b1;
    flip[3] <= 1'b1;
    repeat (100) @(posedge clock);
    chk(halted, 1'b1);
    chk(din_value, 20'h0);
    chk(dout, 8'h0);
    rd(`FIM_OFF_STAT, d);
    chk(d[`FIM_ST_HALT], 1'b1);
    stop_test();
  end
endmodule // tb_top
